// >>> design/nds_dma_ctrl.sv
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module nds_dma_ctrl (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // engine side
    input  wire logic [13:0] ext_events,   // one-cycle event pulses, bit = status bit
    input  wire logic [2:0]  tx_proc_state,// transmit process state code
    input  wire logic        sec_normal,   // secondary status normal summary
    input  wire logic        sec_abnormal, // secondary status abnormal summary
    input  wire logic        bus_err,      // master bus error pulse
    input  wire logic [2:0]  bus_err_code, // cause with bus_err
    input  wire logic        desc_ack,
    input  wire logic        desc_own,
    input  wire logic        frame_arrive,
    input  wire logic        drain_done,
    output logic             desc_req,
    output logic             desc_wr,
    output logic             bus_enable,   // master may use the bus
    output logic             tx_run,       // transmit process enable
    output logic             engine_reset, // internal reset to datapath
    output logic             irq
);
    // ahb data phase capture
    logic        wr_pend_reg;   // write waiting for its data phase
    logic [7:0]  wr_addr_reg;   // its address
    logic        addr_take;     // valid address phase this cycle

    // registers
    logic [31:0] rx_poll_register_reg; // poll demand, stores last write
    logic [29:0] rx_list_start_reg;    // receive list start, word address
    logic [29:0] tx_list_start_reg;    // transmit list start, word address
    logic [31:0] latch_reg;            // sticky status bits
    logic [2:0]  bus_error_cause_reg;  // cause of fatal fault
    logic [31:0] int_mask_reg;         // interrupt mask, same layout
    logic [2:0]  ctrl_reg;             // control bits
    logic [2:0]  tx_state_reg;         // sampled transmit state
    logic [2:0]  srst_cnt_reg;         // software reset countdown
    logic        poll_pulse_reg;       // accepted poll demand

    // decoded write strobes
    logic        wr_ctrl;
    logic        wr_poll;
    logic        wr_rxb;
    logic        wr_txb;
    logic        wr_stat;
    logic        wr_mask;
    logic        srst_active;
    logic [31:0] status_word;
    logic [31:0] set_vec;
    logic [31:0] latch_next;

    nds_rx_if rx ();

    // write strobe decode, used for every register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // address phase: single word transfers only, other sizes ignored
    assign addr_take = hsel && hready && hsize == 3'h2 &&
                       (htrans == nds_pkg::HTRANS_NONSEQ || htrans == nds_pkg::HTRANS_SEQ);

    assign wr_ctrl = wr_pend_reg && hit(wr_addr_reg, nds_pkg::OFS_CTRL);
    assign wr_poll = wr_pend_reg && hit(wr_addr_reg, nds_pkg::OFS_RX_POLL);
    assign wr_rxb  = wr_pend_reg && hit(wr_addr_reg, nds_pkg::OFS_RX_BASE);
    assign wr_txb  = wr_pend_reg && hit(wr_addr_reg, nds_pkg::OFS_TX_BASE);
    assign wr_stat = wr_pend_reg && hit(wr_addr_reg, nds_pkg::OFS_STATUS);
    assign wr_mask = wr_pend_reg && hit(wr_addr_reg, nds_pkg::OFS_INT_MASK);

    assign srst_active = ctrl_reg[nds_pkg::CTRL_SRST];

    // address phase capture; slave never inserts wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_take && hwrite;
            if (addr_take) wr_addr_reg <= haddr;
        end
    end

    // bus response: always ready and okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // read data registered at the address phase edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_take && !hwrite) begin
            unique case (haddr)
                nds_pkg::OFS_CTRL:     hrdata <= {29'h0, ctrl_reg};
                nds_pkg::OFS_RX_POLL:  hrdata <= rx_poll_register_reg;
                nds_pkg::OFS_RX_BASE:  hrdata <= {rx_list_start_reg, 2'h0};
                nds_pkg::OFS_TX_BASE:  hrdata <= {tx_list_start_reg, 2'h0};
                nds_pkg::OFS_STATUS:   hrdata <= status_word;
                nds_pkg::OFS_INT_MASK: hrdata <= int_mask_reg;
                default:               hrdata <= 32'h00000000; // unmapped reads zero
            endcase
        end
    end

    // control: software reset bit self clears after countdown
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg     <= 3'h0;
            srst_cnt_reg <= 3'h0;
        end else if (srst_active) begin
            // writes during reset are dropped; run bits return to stopped
            if (srst_cnt_reg == 3'h0) begin
                ctrl_reg[nds_pkg::CTRL_SRST] <= 1'b0;
            end else begin
                srst_cnt_reg <= srst_cnt_reg - 3'h1;
            end
        end else if (wr_ctrl) begin
            ctrl_reg <= hwdata[2:0];
            if (hwdata[nds_pkg::CTRL_SRST]) begin
                ctrl_reg[2:1] <= 2'h0;
                srst_cnt_reg  <= 3'(nds_pkg::SRST_CYCLES - 1);
            end
        end
    end

    // poll demand register and its accepted pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_poll_register_reg <= nds_pkg::RST_RX_POLL;
            poll_pulse_reg       <= 1'b0;
        end else begin
            if (wr_poll) rx_poll_register_reg <= hwdata;
            // any value triggers, but only while suspended
            poll_pulse_reg <= wr_poll && rx.state == nds_pkg::RX_SUSP;
        end
    end

    // descriptor base registers: configuration, survive software reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_list_start_reg <= nds_pkg::RST_BASE[31:2];
            tx_list_start_reg <= nds_pkg::RST_BASE[31:2];
        end else begin
            // software must have stopped the process; not enforced
            if (wr_rxb) rx_list_start_reg <= hwdata[31:2];
            if (wr_txb) tx_list_start_reg <= hwdata[31:2];
        end
    end

    // interrupt mask, configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_mask_reg <= nds_pkg::RST_MASK;
        end else if (wr_mask) begin
            int_mask_reg <= hwdata & nds_pkg::LATCH_BITS;
        end
    end

    // sampled transmit state for reporting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_state_reg <= 3'h0;
        end else begin
            tx_state_reg <= tx_proc_state;
        end
    end

    // event sources into sticky bits
    always_comb begin
        set_vec = {18'h0, ext_events} & nds_pkg::LATCH_BITS;
        set_vec[nds_pkg::ST_FBF] = 1'b0;
        // fatal flag only from a real bus error while the bus is live
        set_vec[nds_pkg::ST_FBF] = bus_err && !latch_reg[nds_pkg::ST_FBF];
        set_vec[nds_pkg::ST_RCI] = set_vec[nds_pkg::ST_RCI] | rx.rci_evt;
        set_vec[nds_pkg::ST_RDU] = set_vec[nds_pkg::ST_RDU] | rx.rdu_evt;
        set_vec[nds_pkg::ST_RPS] = set_vec[nds_pkg::ST_RPS] | rx.rps_evt;
        // summaries follow their sources and the secondary status
        set_vec[nds_pkg::ST_NRM] = |(set_vec & nds_pkg::NORMAL_SRC) || sec_normal;
        set_vec[nds_pkg::ST_ABN] = |(set_vec & nds_pkg::ABNORMAL_SRC) || sec_abnormal;
    end

    // write one to clear; set wins; summaries judged after the clear
    always_comb begin
        latch_next = latch_reg;
        if (wr_stat) latch_next = latch_reg & ~(hwdata & nds_pkg::LATCH_BITS);
        // parity fault holds until software reset
        if (bus_error_cause_reg == nds_pkg::BEC_PARITY) begin
            latch_next[nds_pkg::ST_FBF] = latch_reg[nds_pkg::ST_FBF];
        end
        latch_next = latch_next | set_vec;
        latch_next[nds_pkg::ST_NRM] |= |(latch_next & nds_pkg::NORMAL_SRC);
        latch_next[nds_pkg::ST_ABN] |= |(latch_next & nds_pkg::ABNORMAL_SRC);
    end

    // sticky status bits, cleared by software reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_reg <= 32'h00000000;
        end else if (srst_active) begin
            latch_reg <= 32'h00000000;
        end else begin
            latch_reg <= latch_next;
        end
    end

    // bus error cause, captured with the fatal flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_error_cause_reg <= 3'h0;
        end else if (srst_active) begin
            bus_error_cause_reg <= 3'h0;
        end else if (set_vec[nds_pkg::ST_FBF]) begin
            bus_error_cause_reg <= bus_err_code;
        end
    end

    // status word: reserved bits zero, cause only with fatal flag
    always_comb begin
        status_word = latch_reg & nds_pkg::LATCH_BITS;
        status_word[nds_pkg::ST_RXS_LO +: 3] = rx.state;
        status_word[nds_pkg::ST_TXS_LO +: 3] = tx_state_reg;
        status_word[nds_pkg::ST_BEC_LO +: 3] =
            latch_reg[nds_pkg::ST_FBF] ? bus_error_cause_reg : 3'h0;
    end

    // link to receive sequencer
    assign rx.run  = ctrl_reg[nds_pkg::CTRL_RX_RUN];
    assign rx.poll = poll_pulse_reg;
    assign rx.halt = latch_reg[nds_pkg::ST_FBF] || bus_err;
    assign rx.clr  = srst_active;

    nds_rx_seq u_rx_seq (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .rx           (rx.seq),
        .desc_ack     (desc_ack),
        .desc_own     (desc_own),
        .frame_arrive (frame_arrive),
        .drain_done   (drain_done),
        .desc_req_reg (desc_req),
        .desc_wr_reg  (desc_wr)
    );

    // engine side outputs; interrupt ignores cause and state fields
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_enable   <= 1'b0;
            tx_run       <= 1'b0;
            engine_reset <= 1'b0;
            irq          <= 1'b0;
        end else begin
            bus_enable   <= !latch_next[nds_pkg::ST_FBF] && !srst_active;
            tx_run       <= ctrl_reg[nds_pkg::CTRL_TX_RUN] && !latch_next[nds_pkg::ST_FBF];
            engine_reset <= srst_active;
            irq          <= |(latch_next & int_mask_reg & nds_pkg::LATCH_BITS);
        end
    end
endmodule
`default_nettype wire

// >>> design/nds_pkg.sv
package nds_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00; // engine control
    localparam logic [7:0] OFS_RX_POLL   = 8'h10; // receive poll demand
    localparam logic [7:0] OFS_RX_BASE   = 8'h18; // receive list base
    localparam logic [7:0] OFS_TX_BASE   = 8'h20; // transmit list base
    localparam logic [7:0] OFS_STATUS    = 8'h28; // engine status
    localparam logic [7:0] OFS_INT_MASK  = 8'h38; // interrupt mask

    // reset values
    localparam logic [31:0] RST_RX_POLL  = 32'h0FFFFFFF;
    localparam logic [31:0] RST_BASE     = 32'h00000000;
    localparam logic [31:0] RST_MASK     = 32'h00000000;

    // control register fields
    localparam int CTRL_SRST   = 0;  // software reset, self clearing
    localparam int CTRL_RX_RUN = 1;  // receive process run
    localparam int CTRL_TX_RUN = 2;  // transmit process run, driven out on tx_run unless the fatal flag is set

    // status register fields
    localparam int ST_TCI  = 0;
    localparam int ST_TPS  = 1;
    localparam int ST_TDU  = 2;
    localparam int ST_TJT  = 3;
    localparam int ST_TUF  = 5;
    localparam int ST_RCI  = 6;
    localparam int ST_RDU  = 7;
    localparam int ST_RPS  = 8;
    localparam int ST_RWT  = 9;
    localparam int ST_GPT  = 11;
    localparam int ST_FBF  = 13;
    localparam int ST_ABN  = 15;
    localparam int ST_NRM  = 16;
    localparam int ST_RXS_LO = 17;
    localparam int ST_TXS_LO = 20;
    localparam int ST_BEC_LO = 23;

    // latching bit groups
    localparam logic [31:0] NORMAL_SRC   = 32'h00000045; // bits 0,2,6
    localparam logic [31:0] ABNORMAL_SRC = 32'h00002BAA; // 1,3,5,7,8,9,11,13
    localparam logic [31:0] LATCH_BITS   = 32'h0001ABEF; // all sticky bits

    // bus error causes
    localparam logic [2:0] BEC_PARITY = 3'h0;
    localparam logic [2:0] BEC_MABORT = 3'h1;
    localparam logic [2:0] BEC_TABORT = 3'h2;

    // software reset duration
    localparam int SRST_CYCLES = 4;

    // receive process states, codes as reported in status
    typedef enum logic [2:0] {
        RX_STOP    = 3'h0,
        RX_DESC_RD = 3'h1,
        RX_CHECK   = 3'h2,
        RX_WAIT    = 3'h3,
        RX_SUSP    = 3'h4,
        RX_DESC_WR = 3'h5,
        RX_FLUSH   = 3'h6,
        RX_DRAIN   = 3'h7
    } nds_rx_state_t;

    // ahb transfer types
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage

// >>> design/nds_rx_if.sv
`timescale 1ns/100ps
`default_nettype none
// control/status link between register block and receive sequencer
interface nds_rx_if;
    logic                   run;        // receive process enabled
    logic                   poll;       // accepted poll demand pulse
    logic                   halt;       // bus access forbidden
    logic                   clr;        // software reset pulse level
    nds_pkg::nds_rx_state_t state;      // current process state
    logic                   rdu_evt;    // descriptor unavailable pulse
    logic                   rps_evt;    // process stopped pulse
    logic                   rci_evt;    // frame stored pulse

    modport ctl (output run, output poll, output halt, output clr,
                 input state, input rdu_evt, input rps_evt, input rci_evt);
    modport seq (input run, input poll, input halt, input clr,
                 output state, output rdu_evt, output rps_evt, output rci_evt);
endinterface
`default_nettype wire

// >>> design/nds_rx_seq.sv
`timescale 1ns/100ps
`default_nettype none
// receive descriptor process sequencer
module nds_rx_seq (
    input  wire logic   hclk,
    input  wire logic   hresetn,
    nds_rx_if.seq       rx,
    input  wire logic   desc_ack,     // memory side finished descriptor access
    input  wire logic   desc_own,     // ownership flag of fetched descriptor
    input  wire logic   frame_arrive, // recognised frame waiting in fifo
    input  wire logic   drain_done,   // fifo emptied into buffer
    output logic        desc_req_reg, // descriptor access request
    output logic        desc_wr_reg   // request is a write-back
);
    nds_pkg::nds_rx_state_t state_reg;
    nds_pkg::nds_rx_state_t state_next;

    assign rx.state = state_reg;

    // next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            nds_pkg::RX_STOP: begin
                if (rx.run) state_next = nds_pkg::RX_DESC_RD;
            end
            nds_pkg::RX_DESC_RD: begin
                // ownership test on fetched descriptor
                if (desc_ack && !rx.halt) begin
                    state_next = desc_own ? nds_pkg::RX_WAIT : nds_pkg::RX_SUSP;
                end
            end
            nds_pkg::RX_WAIT: begin
                if (frame_arrive) state_next = nds_pkg::RX_DRAIN;
            end
            nds_pkg::RX_DRAIN: begin
                if (drain_done) state_next = nds_pkg::RX_CHECK;
            end
            nds_pkg::RX_CHECK: begin
                state_next = nds_pkg::RX_DESC_WR;
            end
            nds_pkg::RX_DESC_WR: begin
                if (desc_ack && !rx.halt) state_next = nds_pkg::RX_DESC_RD;
            end
            nds_pkg::RX_SUSP: begin
                // restart on poll or new frame
                if (rx.poll || frame_arrive) state_next = nds_pkg::RX_DESC_RD;
            end
            nds_pkg::RX_FLUSH: begin
                state_next = nds_pkg::RX_STOP;
            end
        endcase
        // stop request: a frame in flight is flushed first
        if (!rx.run && state_reg != nds_pkg::RX_STOP) begin
            state_next = (state_reg == nds_pkg::RX_DRAIN) ? nds_pkg::RX_FLUSH
                                                          : nds_pkg::RX_STOP;
        end
    end

    // state register, cleared also by software reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= nds_pkg::RX_STOP;
        end else if (rx.clr) begin
            state_reg <= nds_pkg::RX_STOP;
        end else begin
            state_reg <= state_next;
        end
    end

    // descriptor requests, never while bus access is forbidden
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            desc_req_reg <= 1'b0;
            desc_wr_reg  <= 1'b0;
        end else begin
            desc_req_reg <= !rx.clr && !rx.halt && (state_next == nds_pkg::RX_DESC_RD ||
                            state_next == nds_pkg::RX_DESC_WR);
            desc_wr_reg  <= (state_next == nds_pkg::RX_DESC_WR);
        end
    end

    // one-cycle event pulses for the status register
    assign rx.rdu_evt = (state_reg == nds_pkg::RX_DESC_RD) && (state_next == nds_pkg::RX_SUSP);
    assign rx.rps_evt = (state_reg != nds_pkg::RX_STOP) && (state_next == nds_pkg::RX_STOP);
    assign rx.rci_evt = (state_reg == nds_pkg::RX_DESC_WR) && (state_next == nds_pkg::RX_DESC_RD);
endmodule
`default_nettype wire

// >>> tb/nds_dma_chk.sv
`timescale 1ns/100ps
`default_nettype none
// passive watcher on the top ports
module nds_dma_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        bus_err,
    input wire logic        desc_req,
    input wire logic        bus_enable,
    input wire logic        tx_run,
    input wire logic        engine_reset
);
    logic       rd_q; // data phase of a word read
    logic       wr_q; // data phase of a word write
    logic [7:0] a_q;  // address of that data phase
    // follow the data phase so read data can be judged by its address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            a_q  <= 8'h00;
        end else if (hready) begin
            rd_q <= hsel && htrans[1] && hsize == 3'h2 && !hwrite;
            wr_q <= hsel && htrans[1] && hsize == 3'h2 && hwrite;
            a_q  <= haddr;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic st_rd = rd_q && a_q == nds_pkg::OFS_STATUS; // status read
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stalled or error");
    a_rx_align: assert property (
        rd_q && a_q == nds_pkg::OFS_RX_BASE |-> hrdata[1:0] == 2'h0)
        else $error("rx base low bits set");
    a_tx_align: assert property (
        rd_q && a_q == nds_pkg::OFS_TX_BASE |-> hrdata[1:0] == 2'h0)
        else $error("tx base low bits set");
    a_status_rsvd: assert property (
        st_rd |-> !hrdata[31:26] && !hrdata[14] && !hrdata[12])
        else $error("status reserved bit set");
    a_cause_valid: assert property (st_rd |-> hrdata[13] || hrdata[25:23] == 3'h0)
        else $error("cause shown without fault");
    a_fatal_stop: assert property (bus_err && bus_enable |=> !bus_enable && !desc_req)
        else $error("bus still used after fault");
    a_srst_start: assert property (wr_q && a_q == 8'h00 && hwdata[0] && !engine_reset
        |-> ##[1:2] engine_reset) else $error("soft reset not started");
    a_srst_width: assert property (
        $rose(engine_reset) |-> engine_reset[*4] ##[1:3] !engine_reset)
        else $error("soft reset length wrong");
    a_srst_quiet: assert property (
        engine_reset[*2] |-> !bus_enable && !tx_run && !desc_req)
        else $error("engine active in soft reset");
endmodule
bind nds_dma_ctrl nds_dma_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bus_err(bus_err),
    .desc_req(desc_req), .bus_enable(bus_enable), .tx_run(tx_run), .engine_reset(engine_reset));
`default_nettype wire

// >>> tb/nds_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// host memory answering descriptor fetches after a chosen delay
module nds_mem_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       desc_req,
    input  wire logic       own_sel,  // ownership flag to return
    input  wire logic [3:0] dly,      // extra wait before answering
    output logic            desc_ack,
    output logic            desc_own
);
    logic [3:0] cnt_reg; // cycles the request has waited
    // one ack per request; own flag toggles when not qualified
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg  <= 4'h0;
            desc_ack <= 1'b0;
            desc_own <= 1'b0;
        end else if (desc_req && !desc_ack && cnt_reg >= dly) begin
            desc_ack <= 1'b1;
            desc_own <= own_sel;
            cnt_reg  <= 4'h0;
        end else begin
            desc_ack <= 1'b0;
            desc_own <= ~desc_own; // never a stale flag between answers
            cnt_reg  <= (desc_req && !desc_ack) ? cnt_reg + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// >>> tb/test_nds_dma_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module test_nds_dma_ctrl;
    localparam logic [7:0] ST = nds_pkg::OFS_STATUS;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, bus_err, own_sel;
    logic        desc_req, desc_ack, desc_own, bus_enable, engine_reset, sn, sa, fa, dd;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize, tx_st, bec;
    logic [13:0] ev;
    logic [31:0] hwdata, hrdata, v;
    logic [3:0]  dly;
    int          errors, checks, bl[10] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 11};
    nds_dma_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_events(ev),
        .tx_proc_state(tx_st), .sec_normal(sn), .sec_abnormal(sa), .bus_err(bus_err),
        .bus_err_code(bec), .desc_ack(desc_ack), .desc_own(desc_own), .frame_arrive(fa),
        .drain_done(dd), .desc_req(desc_req), .desc_wr(), .bus_enable(bus_enable), .tx_run(),
        .engine_reset(engine_reset), .irq(irq));
    nds_mem_model mem (.hclk(hclk), .hresetn(hresetn), .desc_req(desc_req), .own_sel(own_sel),
        .dly(dly), .desc_ack(desc_ack), .desc_own(desc_own));
    // compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one single ahb transfer, zero-wait or stretched
    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= nds_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(hrdata, e);
    endtask
    // poll status until the receive state shows up
    task wait_rx(input logic [2:0] s);
        for (int i = 0; i < 40; i++) begin
            bus(ST, 1'b0, 32'h0);
            if (hrdata[19:17] === s) break;
        end
        chk({29'h0, hrdata[19:17]}, {29'h0, s});
    endtask
    // one clock edge wait, used to time the event input pulses
    task edge1();
        @(posedge hclk);
    endtask
    function logic [31:0] ev_exp(input int b);
        return (32'h1 << b) | (nds_pkg::NORMAL_SRC[b] ? 32'h10000 : 32'h8000);
    endfunction
    task stop_test();
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // watchdog well past the expected run
    initial begin
        #200000;
        errors++;
        stop_test();
    end
    initial begin
        {hresetn, hsel, hwrite, bus_err, own_sel, sn, sa, fa, dd} = '0;
        haddr = 8'h00; htrans = 2'h0; hsize = 3'h2; tx_st = 3'h0; bec = 3'h0;
        ev = 14'h0; hwdata = 32'h0; dly = 4'h1; errors = 0; checks = 0;
        void'($urandom(80407));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(nds_pkg::OFS_RX_POLL, nds_pkg::RST_RX_POLL);
        rd_chk(ST, 32'h0);
        // base writes with both processes stopped
        repeat (4) begin
            v = $urandom;
            bus(nds_pkg::OFS_RX_BASE, 1'b1, v);
            bus(nds_pkg::OFS_TX_BASE, 1'b1, ~v);
            rd_chk(nds_pkg::OFS_RX_BASE, v & 32'hFFFFFFFC);
            rd_chk(nds_pkg::OFS_TX_BASE, ~v & 32'hFFFFFFFC);
            bus(8'h30, 1'b1, v);
            rd_chk(8'h30, 32'h0);
        end
        for (int c = 0; c < 8; c++) begin
            tx_st <= 3'(c);
            rd_chk(ST, 32'(c) << 20);
        end
        tx_st <= 3'h0;
        // each sticky event: summary, mask, irq, write-one clear
        foreach (bl[i]) begin
            edge1(); ev <= 14'h1 << bl[i];
            edge1(); ev <= 14'h0;
            rd_chk(ST, ev_exp(bl[i]));
            bus(nds_pkg::OFS_INT_MASK, 1'b1, nds_pkg::LATCH_BITS & ~ev_exp(bl[i]));
            rd_chk(ST, ev_exp(bl[i]));
            chk({31'h0, irq}, 32'h0);
            bus(nds_pkg::OFS_INT_MASK, 1'b1, 32'h1 << bl[i]);
            rd_chk(ST, ev_exp(bl[i]));
            chk({31'h0, irq}, 32'h1);
            bus(ST, 1'b1, 32'hFFFFFFFF);
            rd_chk(ST, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        bus(nds_pkg::OFS_INT_MASK, 1'b1, 32'h0);
        for (int k = 0; k < 2; k++) begin
            edge1(); {sa, sn} <= k ? 2'b10 : 2'b01;
            edge1(); {sa, sn} <= 2'b00;
            rd_chk(ST, k ? 32'h8000 : 32'h10000);
            bus(ST, 1'b1, 32'hFFFFFFFF);
        end
        // receive flow: unowned, poll, frame, write-back, stop
        dly <= 4'($urandom_range(3));
        bus(8'h00, 1'b1, 32'h2);
        wait_rx(3'h4);
        rd_chk(ST, 32'h00088080);
        own_sel <= 1'b1;
        bus(nds_pkg::OFS_RX_POLL, 1'b1, $urandom);
        wait_rx(3'h3);
        edge1(); fa <= 1'b1;
        edge1(); fa <= 1'b0;
        wait_rx(3'h7);
        edge1(); dd <= 1'b1;
        edge1(); dd <= 1'b0;
        wait_rx(3'h3);
        rd_chk(ST, 32'h000780C0);
        bus(8'h00, 1'b1, 32'h0);
        wait_rx(3'h0);
        rd_chk(ST, 32'h000181C0);
        bus(ST, 1'b1, 32'hFFFFFFFF);
        // fatal faults: target, master, then parity
        for (int c = 2; c >= 0; c--) begin
            edge1(); bus_err <= 1'b1; bec <= 3'(c);
            edge1(); bus_err <= 1'b0;
            rd_chk(ST, (32'(c) << 23) | 32'hA000);
            chk({31'h0, bus_enable}, 32'h0);
            bus(ST, 1'b1, 32'hFFFFFFFF);
            rd_chk(ST, c == 0 ? 32'hA000 : 32'h0);
        end
        bus(8'h00, 1'b1, 32'h1);
        rd_chk(8'h00, 32'h1);
        repeat (8) @(posedge hclk);
        rd_chk(8'h00, 32'h0);
        rd_chk(ST, 32'h0);
        chk({31'h0, bus_enable}, 32'h1);
        stop_test();
    end
endmodule
`default_nettype wire
